// >>> design/acm_regs.svh
// register offsets, field positions and reset values for the converter control block
`ifndef ACM_REGS_SVH
`define ACM_REGS_SVH
`define ACM_OFF_CTRL3     12'h054
`define ACM_OFF_TEST      12'h058
`define ACM_OFF_AMUX      12'h05c
`define ACM_OFF_IRQ_STAT  12'h060
`define ACM_OFF_IRQ_CLR   12'h064
`define ACM_OFF_IRQ_EN    12'h068
`define ACM_C3_INJ_IEN    9
`define ACM_C3_ANY_IEN    8
`define ACM_C3_RSVD1      7
`define ACM_C3_PWR        6
`define ACM_C3_RDY        5
`define ACM_C3_CKSEL      4
`define ACM_C3_VREF_RDY   2
`define ACM_C3_VREF_EN    1
`define ACM_C3_REFERENCE_SOURCE_SELECT     0
`define ACM_C3_RSVD_LO    10
`define ACM_TEST_EN       0
`define ACM_AM_SETTLE_LO  16
`define ACM_AM_SETTLE_W   10
`define ACM_AM_CH_LO      4
`define ACM_AM_CH_W       3
`define ACM_AM_EN_LO      0
`define ACM_AM_TOP        25
`define ACM_IRQ_ANY       0
`define ACM_IRQ_INJ       1
`define ACM_IRQ_VREF      2
`define ACM_IRQ_SETTLED   3
`define ACM_IRQ_W         4
`define ACM_SLOTS         4
`define ACM_ZERO32        32'h0000_0000
`endif

// >>> design/acm_pkg.sv
// types shared by the converter control block
package acm_pkg;
    typedef enum logic [1:0] {
        ACM_IDLE,
        ACM_SETTLE,
        ACM_DONE
    } acm_settle_state_t;
endpackage

// >>> design/acm_sync3.sv
// three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module acm_sync3 (
    input  wire logic pclk,     // clock
    input  wire logic presetn,  // async reset, active low
    input  wire logic ce,       // clock enable
    input  wire logic d,        // asynchronous input
    output logic      q         // filtered level
);
    logic s1;
    logic s2;
    logic s3;

    // shift chain and agreement filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q  <= 1'b0;
        end else if (ce) begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q <= s3;
            end
        end
    end
endmodule

// >>> design/acm_ctrl.sv
// converter control, test and amplifier mux sequencing registers with apb slave
//
// Contract
// - bit 9 enables injected conversion end interrupt
// - bit 8 enables any-channel conversion end interrupt
// - bit 7 always reads as one
// - read-only bit 6 reads one while converter powered down
// - bit 4 selects clock source: zero synchronous, one pll
// - bit 2 reports internal reference buffer ready
// - bit 1 enables internal reference buffer and measurement path
// - bit 0 selects external or internal reference
// - bits 31:10 reserved, kept at reset value zero
// - test register bit 0 selects normal or test mode
// - bits 25:16 give mux settling delay in converter cycles
// - four three-bit channel fields for injected slots four to one
// - bits 3:0 enable mux switching per injected slot
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "acm_regs.svh"
module acm_ctrl #(
    parameter int SETTLE_W = `ACM_AM_SETTLE_W      // settling counter width
) (
    input  wire logic        pclk,            // converter clock
    input  wire logic        presetn,         // async reset, active low
    input  wire logic        ce,              // clock enable, freezes state
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb enable
    input  wire logic        pwrite,          // apb direction
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    input  wire logic [3:0]  pstrb,           // apb byte strobes
    output logic [31:0]      prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // apb error
    input  wire logic        any_end_flag,    // any conversion end status
    input  wire logic        injected_end_flag, // injected conversion end status
    input  wire logic        power_down_in,   // analog power-down state, async
    input  wire logic        conv_ready_in,   // analog ready, async
    input  wire logic        vref_ready_in,   // reference buffer ready, async
    input  wire logic        slot_start,      // pulse: injected slot begins
    input  wire logic [1:0]  slot_index,      // slot number minus one
    output logic             clock_source_select,        // 0 sync, 1 pll
    output logic             internal_ref_buffer_enable, // buffer on
    output logic             reference_source_select,    // 0 ext, 1 internal
    output logic             test_mode,       // test mode select
    output logic [2:0]       amp_channel,     // mux channel driven
    output logic             amp_switching,   // mux settling in progress
    output logic             amp_settled,     // pulse: settling done
    output logic             irq_any_end,     // gated any-end request
    output logic             irq_inj_end,     // gated injected-end request
    output logic             irq              // combined level interrupt
);
    logic [31:0] ctrl3;
    logic [31:0] testreg;
    logic [31:0] amux;
    logic [`ACM_IRQ_W-1:0] irq_stat;
    logic [`ACM_IRQ_W-1:0] irq_en;
    logic        pwr_s;
    logic        rdy_s;
    logic        vrdy_s;
    logic        vrdy_d;
    logic        any_d;
    logic        inj_d;
    logic        wr;
    logic        rd;
    logic        mapped;
    logic [SETTLE_W-1:0] settle_cnt;
    acm_pkg::acm_settle_state_t st;
    acm_pkg::acm_settle_state_t next_st;
    logic [31:0] wmask;
    logic [31:0] rd_ctrl3;
    logic [`ACM_IRQ_W-1:0] events;
    logic        slot_go;

    // asynchronous analog status through three synchroniser flops and a filter flop
    acm_sync3 u_pwr (.pclk(pclk), .presetn(presetn), .ce(ce), .d(power_down_in), .q(pwr_s));
    acm_sync3 u_rdy (.pclk(pclk), .presetn(presetn), .ce(ce), .d(conv_ready_in), .q(rdy_s));
    acm_sync3 u_vr  (.pclk(pclk), .presetn(presetn), .ce(ce), .d(vref_ready_in), .q(vrdy_s));

    // apb decode, zero wait states
    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite && ce;
    assign rd      = psel && !pwrite;
    assign mapped  = (paddr == `ACM_OFF_CTRL3) || (paddr == `ACM_OFF_TEST) ||
                     (paddr == `ACM_OFF_AMUX) || (paddr == `ACM_OFF_IRQ_STAT) ||
                     (paddr == `ACM_OFF_IRQ_CLR) || (paddr == `ACM_OFF_IRQ_EN);
    assign pslverr = psel && penable && !mapped;
    assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // writable control bits of control register three
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl3 <= `ACM_ZERO32;
        end else if (wr && paddr == `ACM_OFF_CTRL3) begin
            ctrl3[`ACM_C3_INJ_IEN] <= wmask[`ACM_C3_INJ_IEN] ? pwdata[`ACM_C3_INJ_IEN]
                                                           : ctrl3[`ACM_C3_INJ_IEN];
            ctrl3[`ACM_C3_ANY_IEN] <= wmask[`ACM_C3_ANY_IEN] ? pwdata[`ACM_C3_ANY_IEN]
                                                           : ctrl3[`ACM_C3_ANY_IEN];
            ctrl3[`ACM_C3_CKSEL]   <= wmask[`ACM_C3_CKSEL] ? pwdata[`ACM_C3_CKSEL]
                                                         : ctrl3[`ACM_C3_CKSEL];
            ctrl3[`ACM_C3_VREF_EN] <= wmask[`ACM_C3_VREF_EN] ? pwdata[`ACM_C3_VREF_EN]
                                                           : ctrl3[`ACM_C3_VREF_EN];
            ctrl3[`ACM_C3_REFERENCE_SOURCE_SELECT]  <= wmask[`ACM_C3_REFERENCE_SOURCE_SELECT] ? pwdata[`ACM_C3_REFERENCE_SOURCE_SELECT]
                                                          : ctrl3[`ACM_C3_REFERENCE_SOURCE_SELECT];
        end
    end

    // test register, only bit 0 stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            testreg <= `ACM_ZERO32;
        end else if (wr && paddr == `ACM_OFF_TEST && wmask[`ACM_TEST_EN]) begin
            testreg[`ACM_TEST_EN] <= pwdata[`ACM_TEST_EN];
        end
    end

    // amplifier mux register, bits 25:0 stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amux <= `ACM_ZERO32;
        end else if (wr && paddr == `ACM_OFF_AMUX) begin
            amux[`ACM_AM_TOP:0] <= (pwdata[`ACM_AM_TOP:0] & wmask[`ACM_AM_TOP:0]) |
                                   (amux[`ACM_AM_TOP:0] & ~wmask[`ACM_AM_TOP:0]);
        end
    end

    // readback view of control register three
    always_comb begin
        rd_ctrl3 = ctrl3;
        rd_ctrl3[`ACM_C3_RSVD1]   = 1'b1;
        rd_ctrl3[`ACM_C3_PWR]     = pwr_s;
        rd_ctrl3[`ACM_C3_RDY]     = rdy_s;
        rd_ctrl3[`ACM_C3_VREF_RDY] = vrdy_s;
    end

    // read data mux, registered at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `ACM_ZERO32;
        end else if (ce && rd && !penable) begin
            case (paddr)
                `ACM_OFF_CTRL3:    prdata <= rd_ctrl3;
                `ACM_OFF_TEST:     prdata <= testreg;
                `ACM_OFF_AMUX:     prdata <= amux;
                `ACM_OFF_IRQ_STAT: prdata <= {28'h000_0000, irq_stat};
                `ACM_OFF_IRQ_EN:   prdata <= {28'h000_0000, irq_en};
                default:           prdata <= `ACM_ZERO32;
            endcase
        end
    end

    // control outputs
    assign clock_source_select        = ctrl3[`ACM_C3_CKSEL];
    assign internal_ref_buffer_enable = ctrl3[`ACM_C3_VREF_EN];
    assign reference_source_select    = ctrl3[`ACM_C3_REFERENCE_SOURCE_SELECT];
    assign test_mode                  = testreg[`ACM_TEST_EN];

    // conversion end requests gated by enables
    assign irq_any_end = any_end_flag && ctrl3[`ACM_C3_ANY_IEN];
    assign irq_inj_end = injected_end_flag && ctrl3[`ACM_C3_INJ_IEN];

    // slot start that asks for a mux switch
    assign slot_go = slot_start && amux[`ACM_AM_EN_LO + slot_index];

    // settling sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= acm_pkg::ACM_IDLE;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // next state for settling sequencer
    always_comb begin
        next_st = st;
        case (st)
            acm_pkg::ACM_IDLE: begin
                if (slot_go) begin
                    next_st = acm_pkg::ACM_SETTLE;
                end
            end
            acm_pkg::ACM_SETTLE: begin
                if (settle_cnt == '0) begin
                    next_st = acm_pkg::ACM_DONE;
                end
            end
            acm_pkg::ACM_DONE: next_st = acm_pkg::ACM_IDLE;
            default:           next_st = acm_pkg::ACM_IDLE;
        endcase
    end

    // channel latch and settle counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_channel <= 3'h0;
            settle_cnt  <= '0;
        end else if (ce) begin
            if (st == acm_pkg::ACM_IDLE && slot_go) begin
                amp_channel <= amux[`ACM_AM_CH_LO + `ACM_AM_CH_W*slot_index
                                    +: `ACM_AM_CH_W];
                settle_cnt  <= amux[`ACM_AM_SETTLE_LO +: SETTLE_W];
            end else if (st == acm_pkg::ACM_SETTLE && settle_cnt != '0) begin
                settle_cnt <= settle_cnt - 1'b1;
            end
        end
    end

    // sequencer status outputs
    assign amp_switching = (st == acm_pkg::ACM_SETTLE);
    assign amp_settled   = (st == acm_pkg::ACM_DONE);

    // delayed copies for vref ready, any-end and injected-end rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vrdy_d <= 1'b0;
            any_d  <= 1'b0;
            inj_d  <= 1'b0;
        end else if (ce) begin
            vrdy_d <= vrdy_s;
            any_d  <= any_end_flag;
            inj_d  <= injected_end_flag;
        end
    end

    // one-cycle event pulses for the sticky status
    assign events = {amp_settled, vrdy_s && !vrdy_d,
                     injected_end_flag && !inj_d, any_end_flag && !any_d};

    // sticky status, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else if (ce) begin
            if (wr && paddr == `ACM_OFF_IRQ_CLR) begin
                irq_stat <= (irq_stat & ~pwdata[`ACM_IRQ_W-1:0]) | events;
            end else begin
                irq_stat <= irq_stat | events;
            end
        end
    end

    // interrupt enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en <= '0;
        end else if (wr && paddr == `ACM_OFF_IRQ_EN) begin
            irq_en <= pwdata[`ACM_IRQ_W-1:0];
        end
    end

    // level interrupt from enabled status
    assign irq = |(irq_stat & irq_en);

    // assertions on register, interrupt and sequencer behaviour
    a_inj_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `ACM_OFF_CTRL3 && wmask[`ACM_C3_INJ_IEN] && !pwdata[`ACM_C3_INJ_IEN])
        |=> !irq_inj_end)
        else $error("injected irq while its enable is clear");
    a_any_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `ACM_OFF_CTRL3 && wmask[`ACM_C3_ANY_IEN] && pwdata[`ACM_C3_ANY_IEN])
        ##1 any_end_flag |-> irq_any_end)
        else $error("any-end irq missing while enabled");
    a_rsvd_one: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && rd && !penable && paddr == `ACM_OFF_CTRL3) |=> prdata[`ACM_C3_RSVD1])
        else $error("reserved bit 7 not one");
    a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && rd && !penable && paddr == `ACM_OFF_CTRL3)
        |=> (prdata >> `ACM_C3_RSVD_LO) == '0)
        else $error("reserved high bits not zero");
    a_pwr_view: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && rd && !penable && paddr == `ACM_OFF_CTRL3)
        |=> prdata[`ACM_C3_PWR] == $past(pwr_s))
        else $error("power bit mismatch");
    a_ck_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `ACM_OFF_CTRL3 && wmask[`ACM_C3_CKSEL])
        |=> clock_source_select == $past(pwdata[`ACM_C3_CKSEL]))
        else $error("clock select not written");
    a_test_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `ACM_OFF_TEST && wmask[`ACM_TEST_EN])
        |=> test_mode == $past(pwdata[`ACM_TEST_EN]))
        else $error("test mode not written");
    a_settle_len: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st == acm_pkg::ACM_SETTLE && settle_cnt != '0) |=> amp_switching)
        else $error("settling ended early");
    a_settle_done: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st == acm_pkg::ACM_SETTLE && settle_cnt == '0) |=> amp_settled)
        else $error("settled pulse missing");
    a_no_switch: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st == acm_pkg::ACM_IDLE && slot_start && !slot_go) |=> !amp_switching)
        else $error("switch on disabled slot");
    a_slot_load: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st == acm_pkg::ACM_IDLE && slot_go) |=> amp_switching)
        else $error("enabled slot did not switch");
    a_chan_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (st != acm_pkg::ACM_IDLE) |=> $stable(amp_channel))
        else $error("channel changed while settling");
    a_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        !ce |=> ($stable(st) && $stable(settle_cnt)))
        else $error("sequencer moved while clock enable low");
    a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !(wr && paddr == `ACM_OFF_IRQ_CLR))
        |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
        else $error("status bit lost without clear");
endmodule

// >>> verification/adc_ctrl_amp_mux_regs_tb.sv
// self-checking testbench for the converter control register block
`timescale 1ns/1ps
`include "acm_regs.svh"
module adc_ctrl_amp_mux_regs_tb;
    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        any_end_flag;
    logic        injected_end_flag;
    logic        power_down_in;
    logic        conv_ready_in;
    logic        vref_ready_in;
    logic        slot_start;
    logic [1:0]  slot_index;
    logic        clock_source_select;
    logic        internal_ref_buffer_enable;
    logic        reference_source_select;
    logic        test_mode;
    logic [2:0]  amp_channel;
    logic        amp_switching;
    logic        amp_settled;
    logic        irq_any_end;
    logic        irq_inj_end;
    logic        irq;
    int          n_mismatch;
    int          tests_run;
    logic [31:0] rd;
    logic        err;

    acm_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .any_end_flag(any_end_flag),
        .injected_end_flag(injected_end_flag), .power_down_in(power_down_in),
        .conv_ready_in(conv_ready_in), .vref_ready_in(vref_ready_in),
        .slot_start(slot_start), .slot_index(slot_index),
        .clock_source_select(clock_source_select),
        .internal_ref_buffer_enable(internal_ref_buffer_enable),
        .reference_source_select(reference_source_select), .test_mode(test_mode),
        .amp_channel(amp_channel), .amp_switching(amp_switching),
        .amp_settled(amp_settled), .irq_any_end(irq_any_end), .irq_inj_end(irq_inj_end),
        .irq(irq));

    // free-running 8 ns clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer: setup, access until pready under a bound, one idle cycle
    task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(rd, exp);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // reset values, reserved bits and control bit outputs
    task automatic t_ctrl3();
        rchk(`ACM_OFF_CTRL3, 32'h0000_0080);
        rchk(`ACM_OFF_TEST, 32'h0000_0000);
        wr(`ACM_OFF_CTRL3, 32'hffff_ffff);
        rchk(`ACM_OFF_CTRL3, 32'h0000_0393);
        check({29'h0, clock_source_select, internal_ref_buffer_enable,
               reference_source_select}, 32'h0000_0007);
        wr(`ACM_OFF_CTRL3, 32'h0000_0002);
        check({31'h0, internal_ref_buffer_enable}, 32'h0000_0001);
        check({30'h0, clock_source_select, reference_source_select}, 32'h0000_0000);
        power_down_in <= 1'b1;
        conv_ready_in <= 1'b1;
        vref_ready_in <= 1'b1;
        cycles(8);
        rchk(`ACM_OFF_CTRL3, 32'h0000_00e6);
        power_down_in <= 1'b0;
        cycles(8);
        rchk(`ACM_OFF_CTRL3, 32'h0000_00a6);
        vref_ready_in <= 1'b0;
        cycles(8);
        rchk(`ACM_OFF_CTRL3, 32'h0000_00a2);
        wr(`ACM_OFF_TEST, 32'h0000_0001);
        check({31'h0, test_mode}, 32'h0000_0001);
        wr(`ACM_OFF_TEST, 32'h0000_0000);
        check({31'h0, test_mode}, 32'h0000_0000);
        apb(1'b1, 12'h070, 32'hffff_ffff, rd, err);
        check({31'h0, err}, 32'h0000_0001);
    endtask

    // gated end-of-conversion requests and sticky status
    task automatic t_irq();
        wr(`ACM_OFF_IRQ_CLR, 32'h0000_000f);
        wr(`ACM_OFF_CTRL3, 32'h0000_0000);
        any_end_flag      <= 1'b1;
        injected_end_flag <= 1'b1;
        cycles(2);
        check({30'h0, irq_any_end, irq_inj_end}, 32'h0000_0000);
        wr(`ACM_OFF_CTRL3, 32'h0000_0100);
        check({30'h0, irq_any_end, irq_inj_end}, 32'h0000_0002);
        wr(`ACM_OFF_CTRL3, 32'h0000_0200);
        check({30'h0, irq_any_end, irq_inj_end}, 32'h0000_0001);
        any_end_flag      <= 1'b0;
        injected_end_flag <= 1'b0;
        cycles(2);
        check({31'h0, irq_inj_end}, 32'h0000_0000);
        rchk(`ACM_OFF_IRQ_STAT, 32'h0000_0003);
        check({31'h0, irq}, 32'h0000_0000);
        wr(`ACM_OFF_IRQ_EN, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0001);
        wr(`ACM_OFF_IRQ_CLR, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0000);
        rchk(`ACM_OFF_IRQ_STAT, 32'h0000_0002);
    endtask

    // slot start, returns cycles of switching and settled pulses seen
    task automatic slot(input logic [1:0] idx, output int sw, output int st);
        int n;
        sw = 0;
        st = 0;
        slot_index <= idx;
        slot_start <= 1'b1;
        @(posedge pclk);
        slot_start <= 1'b0;
        for (n = 0; n < 40; n++) begin
            @(posedge pclk);
            if (amp_switching === 1'b1) sw++;
            if (amp_settled === 1'b1) st++;
        end
    endtask

    // settling delay and per-slot channel switching
    task automatic t_amux();
        int sw;
        int st;
        wr(`ACM_OFF_AMUX, 32'hffff_ffff);
        rchk(`ACM_OFF_AMUX, 32'h03ff_ffff);
        wr(`ACM_OFF_AMUX, 32'h0003_0282);
        slot(2'd1, sw, st);
        check({29'h0, amp_channel}, 32'h0000_0005);
        check(sw, 4);
        check(st, 1);
        slot(2'd0, sw, st);
        check(sw, 0);
        check({29'h0, amp_channel}, 32'h0000_0005);
        wr(`ACM_OFF_AMUX, 32'h0000_e008);
        slot(2'd3, sw, st);
        check({29'h0, amp_channel}, 32'h0000_0007);
        check(sw, 1);
        rchk(`ACM_OFF_IRQ_STAT, 32'h0000_000a);
        rchk(`ACM_OFF_IRQ_CLR, 32'h0000_0000);
    endtask

    // clock enable low freezes registers; a mid-run reset clears them
    task automatic t_hold();
        ce <= 1'b0;
        wr(`ACM_OFF_CTRL3, 32'h0000_0013);
        ce <= 1'b1;
        check({29'h0, clock_source_select, internal_ref_buffer_enable,
               reference_source_select}, 32'h0000_0000);
        wr(`ACM_OFF_TEST, 32'h0000_0001);
        wr(`ACM_OFF_IRQ_EN, 32'h0000_0008);
        check({31'h0, irq}, 32'h0000_0001);
        presetn <= 1'b0;
        cycles(2);
        presetn <= 1'b1;
        cycles(2);
        check({30'h0, test_mode, irq}, 32'h0000_0000);
        rchk(`ACM_OFF_CTRL3, 32'h0000_0080);
        rchk(`ACM_OFF_AMUX, 32'h0000_0000);
    endtask

    initial begin
        n_mismatch = 0;
        tests_run = 0;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        any_end_flag = 1'b0;
        injected_end_flag = 1'b0;
        power_down_in = 1'b0;
        conv_ready_in = 1'b0;
        vref_ready_in = 1'b0;
        slot_start = 1'b0;
        slot_index = 2'd0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        cycles(6);
        t_ctrl3();
        t_irq();
        t_amux();
        t_hold();
        finish_test();
    end
endmodule
